// [verilog/tcac_ctrl.sv]
/*
 Conversion sequencer, limit comparator and alert driver of a two-channel
 temperature monitor. Assumes a serial-bus slave in front of the register
 port and an integrating converter that returns one signed sample per
 request.
*/
// The placing of the registers and the strobed register port were chosen for this implementation.
`default_nettype none

// Functional notes
// - automatic conversions need standby pin high and software standby clear
// - a one-shot command runs one conversion of both channels
// - conversion rate register sets interval between automatic conversions
// - sources steered remote then local; measurement phase lasts about 60 ms
// - each result stored as an 8-bit two's-complement value
// - results compared with channel limits; outcome kept as status flags
// - out-of-limit result pulls the open-drain alert low
// - both channels converted; both results updated together on success
// - both address pins sampled at every conversion start, three levels each
// - each result is the average of ten measurement cycles
// - no clock-low timeout; bus may stall indefinitely
// - configuration bit 7 set masks alert; clear lets it assert
// - standby pin low: no conversions, one-shot ignored
// - one-shot still converts both channels in software standby
// - after reset the block runs free-running conversions
module tcac_ctrl
    import tcac_pkg::*;
#(
    parameter int unsigned MEAS_CYC_P = MEAS_CYC,
    parameter int unsigned RATE_UNIT_P = RATE_UNIT_CYC
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic hw_standby_pin,
    input wire logic [1:0] addr_sel_pin_a,
    input wire logic [1:0] addr_sel_pin_b,
    output logic [1:0] addr_code_a,
    output logic [1:0] addr_code_b,
    output logic alert_o,
    output logic alert_oe_n,
    // converter
    output logic adc_start,
    output logic adc_remote,
    input wire logic adc_done,
    input wire logic [7:0] adc_sample,
    output logic conv_busy
);

    function automatic logic [7:0] avg10(input logic [11:0] acc);
        avg10 = 8'($signed(acc) / 12'sd10);
    endfunction

    // {above high, below low}
    function automatic logic [1:0] out_lim(input logic [7:0] t,
        input logic [7:0] hi, input logic [7:0] lo);
        out_lim = {$signed(t) > $signed(hi), $signed(t) < $signed(lo)};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    tcac_state_e state_reg, state_next;
    logic [7:0] cfg_reg, cfg_next, rate_reg, rate_next;
    logic [7:0] lhi_reg, lhi_next, llo_reg, llo_next;
    logic [7:0] rhi_reg, rhi_next, rlo_reg, rlo_next;
    logic [7:0] loc_reg, loc_next, rem_reg, rem_next;
    logic [7:0] stat_reg, stat_next, rdata_reg, rdata_next;
    logic [1:0] adda_reg, adda_next, addb_reg, addb_next;
    logic osh_reg, osh_next, chan_reg, chan_next;
    logic [3:0] samp_reg, samp_next;
    logic [11:0] racc_reg, racc_next, lacc_reg, lacc_next;
    logic [31:0] per_reg, per_next, meas_reg, meas_next;
    logic free_run, start, wr_osh;
    logic [7:0] loc_avg, rem_avg;
    logic [1:0] loc_cmp, rem_cmp;
    logic [2:0] rate_sel;

    assign free_run = hw_standby_pin && !cfg_reg[CFG_HW_STANDBY_PIN_BIT];
    assign wr_osh = reg_wr && reg_addr == CMD_ONESHOT;
    assign start = state_reg == ST_IDLE && hw_standby_pin
        && (osh_reg || (free_run && per_reg == 32'h0));
    assign loc_avg = avg10(lacc_reg);
    assign rem_avg = avg10(racc_reg);
    assign loc_cmp = out_lim(loc_avg, lhi_reg, llo_reg);
    assign rem_cmp = out_lim(rem_avg, rhi_reg, rlo_reg);
    assign rate_sel = rate_reg > 8'(RATE_MAX) ? RATE_MAX : rate_reg[2:0];

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb
    begin
        state_next = state_reg;
        chan_next = chan_reg;
        samp_next = samp_reg;
        racc_next = racc_reg;
        lacc_next = lacc_reg;
        adda_next = adda_reg;
        addb_next = addb_reg;
        meas_next = meas_reg;
        per_next = per_reg;
        osh_next = osh_reg;
        if (wr_osh && hw_standby_pin)
            osh_next = 1'b1;
        if (free_run && per_reg != 32'h0)
            per_next = per_reg - 32'h1;
        if (meas_reg != MEAS_CYC_P - 1)
            meas_next = meas_reg + 32'h1;
        case (state_reg)
            ST_IDLE:
                if (start)
                begin
                    state_next = ST_LATCH;
                    osh_next = 1'b0;
                    per_next = RATE_UNIT_P << (RATE_MAX - rate_sel);
                end
            ST_LATCH:
            begin
                adda_next = addr_sel_pin_a;
                addb_next = addr_sel_pin_b;
                meas_next = 32'h0;
                chan_next = 1'b1;
                samp_next = 4'h0;
                racc_next = 12'h0;
                lacc_next = 12'h0;
                state_next = ST_REQ;
            end
            ST_REQ:
                state_next = ST_WAIT;
            ST_WAIT:
                if (adc_done)
                begin
                    if (chan_reg)
                        racc_next = racc_reg + 12'($signed(adc_sample));
                    else
                        lacc_next = lacc_reg + 12'($signed(adc_sample));
                    samp_next = samp_reg + 4'h1;
                    state_next = ST_REQ;
                    if (samp_reg + 4'h1 == SAMPLES)
                    begin
                        if (chan_reg)
                        begin
                            chan_next = 1'b0;
                            samp_next = 4'h0;
                        end
                        else
                            state_next = ST_HOLD;
                    end
                end
            ST_HOLD:
                if (meas_reg == MEAS_CYC_P - 1)
                    state_next = ST_DONE;
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (!hw_standby_pin)
        begin
            state_next = ST_IDLE;
            osh_next = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            chan_reg <= 1'b1;
            samp_reg <= 4'h0;
            racc_reg <= 12'h0;
            lacc_reg <= 12'h0;
            adda_reg <= 2'h0;
            addb_reg <= 2'h0;
            meas_reg <= 32'h0;
            per_reg <= 32'h0;
            osh_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            chan_reg <= chan_next;
            samp_reg <= samp_next;
            racc_reg <= racc_next;
            lacc_reg <= lacc_next;
            adda_reg <= adda_next;
            addb_reg <= addb_next;
            meas_reg <= meas_next;
            per_reg <= per_next;
            osh_reg <= osh_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers; the port never stalls, which is why no timeout exists
    always_comb
    begin
        cfg_next = cfg_reg;
        rate_next = rate_reg;
        lhi_next = lhi_reg;
        llo_next = llo_reg;
        rhi_next = rhi_reg;
        rlo_next = rlo_reg;
        loc_next = loc_reg;
        rem_next = rem_reg;
        stat_next = stat_reg;
        rdata_next = 8'h00;
        if (reg_wr)
            case (reg_addr)
                CMD_WR_CFG: cfg_next = reg_wdata & 8'hC0;
                CMD_WR_RATE: rate_next = reg_wdata;
                CMD_WR_LHI: lhi_next = reg_wdata;
                CMD_WR_LLO: llo_next = reg_wdata;
                CMD_WR_RHI: rhi_next = reg_wdata;
                CMD_WR_RLO: rlo_next = reg_wdata;
                default: ;
            endcase
        if (reg_rd)
            case (reg_addr)
                CMD_RD_LOC: rdata_next = loc_reg;
                CMD_RD_REM: rdata_next = rem_reg;
                CMD_RD_STAT:
                begin
                    rdata_next = stat_reg;
                    stat_next = 8'h00;
                end
                CMD_RD_CFG: rdata_next = cfg_reg;
                CMD_RD_RATE: rdata_next = rate_reg;
                CMD_RD_LHI: rdata_next = lhi_reg;
                CMD_RD_LLO: rdata_next = llo_reg;
                CMD_RD_RHI: rdata_next = rhi_reg;
                CMD_RD_RLO: rdata_next = rlo_reg;
                default: rdata_next = 8'h00;
            endcase
        // a new result wins over a clearing status read
        if (state_reg == ST_DONE && hw_standby_pin)
        begin
            loc_next = loc_avg;
            rem_next = rem_avg;
            stat_next[ST_LHI_BIT] |= loc_cmp[1];
            stat_next[ST_LLO_BIT] |= loc_cmp[0];
            stat_next[ST_RHI_BIT] |= rem_cmp[1];
            stat_next[ST_RLO_BIT] |= rem_cmp[0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cfg_reg <= CFG_RST;
            rate_reg <= RATE_RST;
            lhi_reg <= HI_RST;
            llo_reg <= LO_RST;
            rhi_reg <= HI_RST;
            rlo_reg <= LO_RST;
            loc_reg <= TEMP_RST;
            rem_reg <= TEMP_RST;
            stat_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end
        else
        begin
            cfg_reg <= cfg_next;
            rate_reg <= rate_next;
            lhi_reg <= lhi_next;
            llo_reg <= llo_next;
            rhi_reg <= rhi_next;
            rlo_reg <= rlo_next;
            loc_reg <= loc_next;
            rem_reg <= rem_next;
            stat_reg <= stat_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata = rdata_reg;
    assign addr_code_a = adda_reg;
    assign addr_code_b = addb_reg;
    assign alert_o = 1'b0;
    // alert holds while any flag is set and unmasked
    assign alert_oe_n = !(stat_reg != 8'h00
        && !cfg_reg[CFG_MASK_BIT]);
    assign adc_start = state_reg == ST_REQ;
    assign adc_remote = chan_reg;
    assign conv_busy = state_reg != ST_IDLE;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_osh_req;
        wr_osh && hw_standby_pin && state_reg == ST_IDLE ##1 hw_standby_pin;
    endsequence

    a_hw_standby_idle: assert property (
        !hw_standby_pin |=> state_reg == ST_IDLE && !osh_reg)
        else $error("conversion active in hardware standby");
    a_sw_standby_auto: assert property (
        state_reg == ST_IDLE && !free_run && !osh_reg |=> state_reg == ST_IDLE)
        else $error("automatic conversion while stopped");
    a_oneshot_start: assert property (
        s_osh_req |=> state_reg == ST_LATCH)
        else $error("one-shot did not start a conversion");
    a_rate_period: assert property (
        start && !osh_reg |=> state_reg == ST_LATCH
        && per_reg == RATE_UNIT_P << (RATE_MAX - $past(rate_sel)))
        else $error("period not reloaded from rate");
    a_meas_phase: assert property (
        state_reg == ST_DONE |-> meas_reg == MEAS_CYC_P - 1)
        else $error("measurement phase too short");
    a_both_update: assert property (
        state_reg == ST_DONE && hw_standby_pin |=> loc_reg == $past(loc_avg)
        && rem_reg == $past(rem_avg))
        else $error("results not stored together");
    a_flag_set: assert property (
        state_reg == ST_DONE && hw_standby_pin && rem_cmp[1]
        |=> stat_reg[ST_RHI_BIT])
        else $error("remote high flag not set");
    a_alert_drive: assert property (
        state_reg == ST_DONE && hw_standby_pin && loc_cmp != 2'h0
        && cfg_next[CFG_MASK_BIT] == 1'b0 |=> !alert_oe_n)
        else $error("alert not driven low");
    a_alert_mask: assert property (
        cfg_reg[CFG_MASK_BIT] |-> alert_oe_n)
        else $error("masked alert driven");
    a_addr_latch: assert property (
        state_reg == ST_LATCH |=> addr_code_a == $past(addr_sel_pin_a)
        && addr_code_b == $past(addr_sel_pin_b))
        else $error("address pins not latched");
    a_ten_samples: assert property (
        state_reg == ST_DONE |-> samp_reg == SAMPLES && !chan_reg)
        else $error("sample count wrong");

endmodule // tcac_ctrl
`default_nettype wire

// [verilog/tcac_pkg.sv]
/*
 Constants shared by the temperature conversion and alarm controller.
 Assumes a 200 MHz system clock.
*/
`default_nettype none
package tcac_pkg;
    localparam int CLK_MHZ = 200;
    localparam int MEAS_TIME_MS = 60;
    localparam int MEAS_CYC = MEAS_TIME_MS * CLK_MHZ * 1000;
    localparam int RATE_UNIT_MS = 125;
    localparam int RATE_UNIT_CYC = RATE_UNIT_MS * CLK_MHZ * 1000;
    localparam logic [2:0] RATE_MAX = 3'h7;
    // command bytes
    localparam logic [7:0] CMD_RD_LOC = 8'h00;
    localparam logic [7:0] CMD_RD_REM = 8'h01;
    localparam logic [7:0] CMD_RD_STAT = 8'h02;
    localparam logic [7:0] CMD_RD_CFG = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_LHI = 8'h05;
    localparam logic [7:0] CMD_RD_LLO = 8'h06;
    localparam logic [7:0] CMD_RD_RHI = 8'h07;
    localparam logic [7:0] CMD_RD_RLO = 8'h08;
    localparam logic [7:0] CMD_WR_CFG = 8'h09;
    localparam logic [7:0] CMD_WR_RATE = 8'h0A;
    localparam logic [7:0] CMD_WR_LHI = 8'h0B;
    localparam logic [7:0] CMD_WR_LLO = 8'h0C;
    localparam logic [7:0] CMD_WR_RHI = 8'h0D;
    localparam logic [7:0] CMD_WR_RLO = 8'h0E;
    localparam logic [7:0] CMD_ONESHOT = 8'h0F;
    // reset values
    localparam logic [7:0] TEMP_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] HI_RST = 8'h7F;
    localparam logic [7:0] LO_RST = 8'hC9;
    // field positions
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_HW_STANDBY_PIN_BIT = 6;
    localparam int ST_LHI_BIT = 6;
    localparam int ST_LLO_BIT = 5;
    localparam int ST_RHI_BIT = 4;
    localparam int ST_RLO_BIT = 3;
    localparam logic [3:0] SAMPLES = 4'hA;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LATCH, ST_REQ, ST_WAIT, ST_HOLD, ST_DONE
    } tcac_state_e;
endpackage
`default_nettype wire

// [sim/tcac_adc_model.sv]
/*
 converter stand-in: answers each sample request after 1 to 4 cycles.
 assumes one request outstanding at a time.
*/
`default_nettype none
module tcac_adc_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requests
    input wire logic adc_start,
    input wire logic adc_remote,
    input wire logic conv_busy,
    input wire logic [7:0] loc_val,
    input wire logic [7:0] rem_val,
    // answers
    output logic adc_done,
    output logic [7:0] adc_sample = 8'h5A
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 88253;
    logic pend = 1'b0;
    logic odd, rem;
    logic [1:0] dly;
    logic [7:0] d;
    ////////////////////////////////////////////////////////////////////////
    // +d/-d pairs so ten samples average to the exact value
    always @(posedge clk)
    begin
        adc_done <= 1'b0;
        // toggles outside answers so a stale sample never looks valid
        adc_sample <= ~adc_sample;
        if (!conv_busy)
            odd <= 1'b0;
        if (sys_rst)
            pend <= 1'b0;
        else if (adc_start)
        begin
            pend <= 1'b1;
            rem <= adc_remote;
            dly <= 2'($random(seed));
        end
        else if (pend && dly != 2'h0)
            dly <= dly - 2'h1;
        else if (pend)
        begin
            if (!odd)
                d = 8'($random(seed)) & 8'h07;
            pend <= 1'b0;
            adc_done <= 1'b1;
            adc_sample <= (rem ? rem_val : loc_val) + (odd ? 8'h00 - d : d);
            odd <= ~odd;
        end
    end
endmodule // tcac_adc_model
`default_nettype wire

// [sim/tb_top.sv]
/*
 self-checking bench for the conversion and alarm controller.
 assumes short measurement and rate units set through parameters.
*/
`default_nettype none
module tb_top
    import tcac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MEAS = 200;
    localparam int UNIT = 100;
    localparam logic [7:0] RST_V [9] = '{TEMP_RST, TEMP_RST, 8'h00, CFG_RST,
        RATE_RST, HI_RST, LO_RST, HI_RST, LO_RST};
    localparam logic [7:0] LV [6] = '{8'h41, 8'hEF, 8'h10, 8'h10, 8'h40,
        8'h41};
    localparam logic [7:0] RV [6] = '{8'h10, 8'h10, 8'h41, 8'hEF, 8'hF0,
        8'h10};
    localparam logic [7:0] SX [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00,
        8'h40};
    // a start reloads the period counter on its own edge, so starts fall
    // one cycle further apart than the programmed count
    localparam int PER_R2 = (UNIT << 5) + 1;
    localparam int PER_R3 = (UNIT << 4) + 1;
    logic al_exp;
    logic clk, sys_rst, reg_wr, reg_rd, hw_standby_pin, rd_d, busy_q;
    logic alert_o, alert_oe_n, adc_start, adc_remote, adc_done, conv_busy;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, adc_sample;
    logic [7:0] loc_val, rem_val, old_loc;
    logic [1:0] pin_a, pin_b, addr_code_a, addr_code_b, pa1, pb1;
    logic [7:0] expq[$];
    int seed = 88253;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int starts = 0;
    int nrem, nloc, blen, last_rise, prev_rise, n;

    tcac_ctrl #(.MEAS_CYC_P(MEAS), .RATE_UNIT_P(UNIT)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .hw_standby_pin(hw_standby_pin),
        .addr_sel_pin_a(pin_a), .addr_sel_pin_b(pin_b),
        .addr_code_a(addr_code_a), .addr_code_b(addr_code_b),
        .alert_o(alert_o), .alert_oe_n(alert_oe_n), .adc_start(adc_start),
        .adc_remote(adc_remote), .adc_done(adc_done),
        .adc_sample(adc_sample), .conv_busy(conv_busy));
    tcac_adc_model adc_u (
        .clk(clk), .sys_rst(sys_rst), .adc_start(adc_start),
        .adc_remote(adc_remote), .conv_busy(conv_busy), .loc_val(loc_val),
        .rem_val(rem_val), .adc_done(adc_done), .adc_sample(adc_sample));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one strobe cycle; a read notes its expected answer for the monitor
    task automatic bus(input logic w, input logic [7:0] a, d, e);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        if (!w)
            expq.push_back(e);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic wait_lvl(input logic lvl, input int lim);
        int k;
        k = 0;
        @(posedge clk);
        while (conv_busy !== lvl && k < lim)
        begin
            @(posedge clk);
            k++;
        end
        // a wait that runs out shows up as a busy mismatch
        chk("busy level", 16'(conv_busy), 16'(lvl));
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        rd_d <= reg_rd;
        if (rd_d)
            chk("rdata", 16'(reg_rdata), 16'(expq.pop_front()));
        if (conv_busy && !busy_q)
        begin
            nrem = 0;
            nloc = 0;
            blen = 0;
            starts++;
            prev_rise = last_rise;
            last_rise = cyc;
        end
        busy_q = conv_busy;
        blen += int'(conv_busy);
        // a remote request after any local one is left uncounted
        if (adc_start && adc_remote && nloc == 0)
            nrem++;
        if (adc_start && !adc_remote)
            nloc++;
        if (cyc == 30000)
        begin
            mismatches++;
            conclude();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        hw_standby_pin = 1'b1;
        loc_val = 8'($random(seed) % 50);
        rem_val = 8'($random(seed) % 50);
        pin_a = 2'($unsigned($random(seed)) % 3);
        pin_b = 2'($unsigned($random(seed)) % 3);
        pa1 = pin_a;
        pb1 = pin_b;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("busy", 16'(conv_busy), 16'h0001);
        for (int i = 0; i < 9; i++)
            bus(1'b0, 8'(i), 8'h00, RST_V[i]);
        bus(1'b0, 8'h13, 8'h00, 8'h00);
        bus(1'b1, CMD_RD_CFG, 8'hC0, 8'h00);
        bus(1'b0, CMD_RD_CFG, 8'h00, CFG_RST);
        pin_a <= 2'($unsigned($random(seed)) % 3);
        pin_b <= 2'($unsigned($random(seed)) % 3);
        $display("reset test done");
        wait_lvl(1'b0, 400);
        chk("remote n", 16'(nrem), 16'h000A);
        chk("local n", 16'(nloc), 16'h000A);
        chk("span", 16'(blen >= MEAS && blen <= MEAS + 4), 16'h0001);
        chk("addr a", 16'(addr_code_a), 16'(pa1));
        chk("addr b", 16'(addr_code_b), 16'(pb1));
        bus(1'b0, CMD_RD_LOC, 8'h00, loc_val);
        bus(1'b0, CMD_RD_REM, 8'h00, rem_val);
        bus(1'b0, CMD_RD_STAT, 8'h00, 8'h00);
        wait_lvl(1'b1, 4000);
        repeat (3) @(posedge clk);
        chk("addr a2", 16'(addr_code_a), 16'(pin_a));
        chk("addr b2", 16'(addr_code_b), 16'(pin_b));
        chk("period", 16'(last_rise - prev_rise), 16'(PER_R2));
        bus(1'b1, CMD_WR_RATE, 8'h03, 8'h00);
        bus(1'b0, CMD_RD_RATE, 8'h00, 8'h03);
        repeat (2)
        begin
            wait_lvl(1'b0, 400);
            wait_lvl(1'b1, 4000);
        end
        repeat (3) @(posedge clk);
        chk("period", 16'(last_rise - prev_rise), 16'(PER_R3));
        $display("free run test done");
        wait_lvl(1'b0, 400);
        old_loc = loc_val;
        loc_val <= 8'h11;
        bus(1'b1, CMD_ONESHOT, 8'h00, 8'h00);
        wait_lvl(1'b1, 20);
        repeat (50) @(posedge clk);
        hw_standby_pin <= 1'b0;
        repeat (3) @(posedge clk);
        chk("abort", 16'(conv_busy), 16'h0000);
        bus(1'b0, CMD_RD_LOC, 8'h00, old_loc);
        n = starts;
        bus(1'b1, CMD_ONESHOT, 8'h00, 8'h00);
        repeat (400) @(posedge clk);
        chk("hw hw_standby_pin", 16'(starts - n), 16'h0000);
        bus(1'b1, CMD_WR_CFG, 8'h40, 8'h00);
        bus(1'b1, CMD_WR_RATE, 8'h07, 8'h00);
        hw_standby_pin <= 1'b1;
        n = starts;
        repeat (400) @(posedge clk);
        chk("sw hw_standby_pin", 16'(starts - n), 16'h0000);
        $display("standby test done");
        for (int i = 0; i < 4; i++)
            bus(1'b1, CMD_WR_LHI + 8'(i), (i % 2) ? 8'hF0 : 8'h40, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 5)
                bus(1'b1, CMD_WR_CFG, 8'hFF, 8'h00);
            loc_val <= LV[i];
            rem_val <= RV[i];
            bus(1'b1, CMD_ONESHOT, 8'h00, 8'h00);
            wait_lvl(1'b1, 20);
            wait_lvl(1'b0, 400);
            repeat (2) @(posedge clk);
            al_exp = SX[i] == 8'h00 || i == 5;
            chk("alert", 16'(alert_oe_n), 16'(al_exp));
            bus(1'b0, CMD_RD_LOC, 8'h00, LV[i]);
            bus(1'b0, CMD_RD_REM, 8'h00, RV[i]);
            bus(1'b0, CMD_RD_STAT, 8'h00, SX[i]);
            bus(1'b0, CMD_RD_STAT, 8'h00, 8'h00);
            repeat (2) @(posedge clk);
            chk("alert off", 16'(alert_oe_n), 16'h0001);
        end
        bus(1'b0, CMD_RD_CFG, 8'h00, 8'hC0);
        chk("alert data", 16'(alert_o), 16'h0000);
        $display("limit test done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
